// *** core/tsis_regs.vh ***
`ifndef TSIS_REGS_VH
`define TSIS_REGS_VH
// Register byte offsets
`define TSIS_ROUTE_OFF 8'h00
`define TSIS_MODE_OFF 8'h04
`define TSIS_DIV_OFF 8'h08
`define TSIS_GRP_OFF 8'h0c
`define TSIS_TXD_OFF 8'h10
`define TSIS_STAT_OFF 8'h14
`define TSIS_RX1_OFF 8'h18
`define TSIS_RX2_OFF 8'h1c
`define TSIS_RX3_OFF 8'h20
// Reset values
`define TSIS_ROUTE_RST 16'h0000
`define TSIS_MODE_RST 24'h000000
`define TSIS_DIV_RST 16'h0013
`define TSIS_GRP_RST 2'h0
// Routing fields
`define TSIS_RT_MODE_LSB 0
`define TSIS_RT_CH2_BIT 3
`define TSIS_RT_CH3_BIT 4
`define TSIS_MUX_NONE 2'h0
`define TSIS_MUX_PCM 2'h1
`define TSIS_MUX_LINK_A 2'h2
`define TSIS_MUX_LINK_B 2'h3
// Channel mode fields, one byte per channel
`define TSIS_CM_WIDTH 8
`define TSIS_CM_EN 0
`define TSIS_CM_BSYNC 1
`define TSIS_CM_NTS 2
`define TSIS_CM_EXTCLK 3
// Link frame bit boundaries: two bearer slots, one signalling pair
`define TSIS_LINK_B1_END 8'd8
`define TSIS_LINK_B2_END 8'd16
`define TSIS_LINK_D_END 8'd18
`define TSIS_SLOT_BITS 8
`endif

// *** core/tsis_top.v ***
`timescale 1ns/1ps
// Summary of operation
// - Transparent channel moves bits unchanged, no stuffing and no start/stop framing
// - Every bit is shifted on its own clock edge, never by oversampling
// - Bit clock comes from the internal baud generator or from the far end
// - Four routes exist: plain modem pins, PCM highway, two ISDN link ports
// - Each channel owns seven plain pins: data, clocks, rts, cts, cd
// - Multiplexed route carries one, two or three channels on one pin group
// - Multiplexed route uses channel one's pins, so channel one always joins
// - Channels two and three choose mux or own pins independently
// - Either all channels use own pins or channel one drives the mux
// - Link ports carry two 64 kbps bearer slots and a 16 kbps signalling slot
// - PCM highway uses 8-bit slots; slots may be grouped per channel
// - PCM uses one shift clock for both directions, only while sync active
// - Routing register resets to 0000, all channels on own pins
// - Value 0009 puts channels one and two on PCM, three on own pins
// - Channel is transparent when enable, byte-sync protocol and no-transmit-sync bits set
// - Idle transparent transmitter sends continuous ones
`include "tsis_regs.vh"
// ********************************
// Transmit data FIFO
// ********************************
module tsis_fifo #(
   parameter W = 10,
   parameter AW = 4
) (
   input wire pclk,
   input wire presetn,
   input wire in_valid,
   output wire in_ready,
   input wire [W-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [W-1:0] out_data,
   output wire [AW:0] level
);
   reg [W-1:0] mem_q [0:(1<<AW)-1];
   reg [AW:0] wp_q;
   reg [AW:0] rp_q;
   wire push;
   wire pop;
   // Pointers carry one extra bit so full and empty differ
   assign level = wp_q - rp_q;
   assign in_ready = (level != (1 << AW));
   assign out_valid = (wp_q != rp_q);
   assign out_data = mem_q[rp_q[AW-1:0]];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   // Storage has no reset; contents are don't-care until written
   always @(posedge pclk) begin
      if (push) begin
         mem_q[wp_q[AW-1:0]] <= in_data;
      end
   end
   // Pointer update
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wp_q <= {(AW+1){1'b0}};
         rp_q <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wp_q <= wp_q + 1'b1;
         end
         if (pop) begin
            rp_q <= rp_q + 1'b1;
         end
      end
   end
endmodule
// ********************************
// Serial channel router and transparent engines
// ********************************
module tsis_top #(
   parameter FIFO_AW = 4
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire pready,
   output wire pslverr,
   output wire [2:0] txd,
   input wire [2:0] tclk_i,
   output wire [2:0] tclk_o,
   output wire [2:0] tclk_oe_n,
   input wire [2:0] rxd,
   input wire [2:0] rclk,
   output wire [2:0] rts_n,
   input wire [2:0] cts_n,
   input wire [2:0] cd_n
);
   reg [15:0] route_q;
   reg [23:0] mode_q;
   reg [15:0] div_q;
   reg [1:0] grp_q;
   reg [31:0] prdata_q;
   reg pready_q;
   reg pslverr_q;
   reg [15:0] bcnt_q;
   reg bclk_q;
   reg [2:0] tclk_p_q;
   reg [2:0] rclk_p_q;
   reg [7:0] idx_q;
   reg [1:0] own_q;
   reg [2:0] tclk_o_q;
   reg [2:0] tclk_oe_n_q;
   reg [31:0] rd_d;
   reg err_d;
   wire [2:0] bit_w;
   wire [2:0] busy_w;
   wire [2:0] rxf_w;
   wire [23:0] rxb_w;
   wire [2:0] take;
   wire [2:0] rd_clr;
   wire [2:0] run;
   wire [2:0] on_mux;
   wire [2:0] rise_r;
   wire [2:0] fall_t;
   wire [2:0] tx_tick;
   wire [2:0] rx_tick;
   wire [FIFO_AW:0] f_level;
   wire f_in_ready;
   wire f_valid;
   wire [9:0] f_data;
   wire layer_one_shift_clock;
   wire mux_sync;
   wire [1:0] owner;
   wire mux_on;
   wire btick;
   wire done;
   wire push;
   // PCM groups consecutive 8-bit slots; links use fixed B1/B2/D bits
   function [1:0] slot_owner;
      input [1:0] m;
      input [7:0] i;
      input [1:0] g;
      reg [5:0] s;
      reg [5:0] n;
      begin
         s = {1'b0, i[7:3]};
         n = {4'h0, g} + 6'h01;
         if (m == `TSIS_MUX_PCM) begin
            if (s < n)
               slot_owner = 2'h0;
            else if (s < n + n)
               slot_owner = 2'h1;
            else if (s < n + n + n)
               slot_owner = 2'h2;
            else
               slot_owner = 2'h3;
         end else begin
            if (i < `TSIS_LINK_B1_END)
               slot_owner = 2'h0;
            else if (i < `TSIS_LINK_B2_END)
               slot_owner = 2'h1;
            else if (i < `TSIS_LINK_D_END)
               slot_owner = 2'h2;
            else
               slot_owner = 2'h3;
         end
      end
   endfunction
   // Channel one joins any mux route; two and three opt in
   assign mux_on = route_q[`TSIS_RT_MODE_LSB+1:`TSIS_RT_MODE_LSB] != `TSIS_MUX_NONE;
   assign on_mux[0] = mux_on;
   assign on_mux[1] = mux_on & route_q[`TSIS_RT_CH2_BIT];
   assign on_mux[2] = mux_on & route_q[`TSIS_RT_CH3_BIT];
   // Mux route borrows channel one's receive clock and cd pins
   assign layer_one_shift_clock = rise_r[0];
   assign mux_sync = ~cd_n[0];
   assign owner = slot_owner(route_q[1:0], idx_q, grp_q);
   assign rise_r = rclk & ~rclk_p_q;
   assign fall_t = ~tclk_i & tclk_p_q;
   // At or above: a smaller divisor written mid-count must not wait for wrap-around
   assign btick = (bcnt_q >= div_q);
   // Baud generator toggles a shared bit clock; edges act as enables
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bcnt_q <= 16'h0000;
         bclk_q <= 1'b0;
         tclk_p_q <= 3'h0;
         rclk_p_q <= 3'h0;
         idx_q <= 8'h00;
         own_q <= 2'h3;
         tclk_o_q <= 3'h0;
         tclk_oe_n_q <= 3'h7;
      end else begin
         tclk_p_q <= tclk_i;
         rclk_p_q <= rclk;
         if (btick) begin
            bcnt_q <= 16'h0000;
            bclk_q <= ~bclk_q;
         end else begin
            bcnt_q <= bcnt_q + 16'h0001;
         end
         tclk_o_q <= {3{bclk_q}};
         tclk_oe_n_q <= ~(run & ~on_mux & ~{mode_q[19], mode_q[11], mode_q[3]});
         // Bit count restarts whenever sync is released
         if (!mux_sync) begin
            idx_q <= 8'h00;
         end else if (layer_one_shift_clock) begin
            own_q <= owner;
            if (idx_q != 8'hff) begin
               idx_q <= idx_q + 8'h01;
            end
         end
      end
   end

   // ********************************
   // Per-channel transparent engines
   // ********************************
   genvar c;
   generate
      for (c = 0; c < 3; c = c + 1) begin : g_ch
         reg [7:0] sh_q;
         reg [2:0] cnt_q;
         reg bit_q;
         reg busy_q;
         reg [7:0] rxs_q;
         reg [2:0] rxc_q;
         reg [7:0] rxb_q;
         reg rxf_q;
         reg txd_q;
         reg rts_n_q;
         wire ext;
         wire nm_tx;
         wire nm_rx;
         wire mx;
         wire cts_ok;
         // Enable plus byte-sync protocol plus no-transmit-sync selects transparent
         assign run[c] = mode_q[c*8+`TSIS_CM_EN] & mode_q[c*8+`TSIS_CM_BSYNC]
                         & mode_q[c*8+`TSIS_CM_NTS];
         assign ext = mode_q[c*8+`TSIS_CM_EXTCLK];
         // Far-end clock edges or internal baud edges, never oversampled
         assign nm_tx = ext ? fall_t[c] : (btick & bclk_q);
         assign nm_rx = ext ? rise_r[c] : (btick & ~bclk_q);
         // One shift clock for both directions inside the owned slot
         assign mx = layer_one_shift_clock & mux_sync & (owner == c);
         assign tx_tick[c] = run[c] & (on_mux[c] ? mx : nm_tx);
         assign rx_tick[c] = run[c] & (on_mux[c] ? mx : (nm_rx & ~cd_n[c]));
         assign cts_ok = on_mux[c] | ~cts_n[c];
         assign take[c] = tx_tick[c] & (cnt_q == 3'h0) & f_valid
                          & (f_data[9:8] == c) & cts_ok;
         assign bit_w[c] = bit_q;
         assign busy_w[c] = busy_q;
         assign rxf_w[c] = rxf_q;
         assign rxb_w[c*8+7:c*8] = rxb_q;
         // Transmit shifter, msb first, bits passed untouched
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               sh_q <= 8'h00;
               cnt_q <= 3'h0;
               bit_q <= 1'b1;
               busy_q <= 1'b0;
            end else if (!run[c]) begin
               cnt_q <= 3'h0;
               bit_q <= 1'b1;
               busy_q <= 1'b0;
            end else if (tx_tick[c]) begin
               if (cnt_q != 3'h0) begin
                  bit_q <= sh_q[7];
                  sh_q <= {sh_q[6:0], 1'b0};
                  cnt_q <= cnt_q - 3'h1;
               end else if (take[c]) begin
                  bit_q <= f_data[7];
                  sh_q <= {f_data[6:0], 1'b0};
                  cnt_q <= 3'h7;
                  busy_q <= 1'b1;
               end else begin
                  bit_q <= 1'b1;
                  busy_q <= 1'b0;
               end
            end
         end
         // Receive shifter; a new byte beats a read clear
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               rxs_q <= 8'h00;
               rxc_q <= 3'h0;
               rxb_q <= 8'h00;
               rxf_q <= 1'b0;
            end else begin
               if (!run[c]) begin
                  rxc_q <= 3'h0;
               end else if (rx_tick[c]) begin
                  rxs_q <= {rxs_q[6:0], (on_mux[c] ? rxd[0] : rxd[c])};
                  rxc_q <= rxc_q + 3'h1;
               end
               if (rx_tick[c] && run[c] && rxc_q == 3'h7) begin
                  rxb_q <= {rxs_q[6:0], (on_mux[c] ? rxd[0] : rxd[c])};
                  rxf_q <= 1'b1;
               end else if (rd_clr[c]) begin
                  rxf_q <= 1'b0;
               end
            end
         end
         // Pins: channel one carries the mux stream, other muxed channels idle high
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               txd_q <= 1'b1;
               rts_n_q <= 1'b1;
            end else begin
               if (c == 0 && on_mux[0]) begin
                  txd_q <= (own_q == 2'h3) ? 1'b1 :
                           (on_mux[own_q] ? bit_w[own_q] : 1'b1);
               end else if (on_mux[c]) begin
                  txd_q <= 1'b1;
               end else begin
                  txd_q <= bit_q;
               end
               rts_n_q <= ~(busy_q & ~on_mux[c]);
            end
         end
         assign txd[c] = txd_q;
         assign rts_n[c] = rts_n_q;
      end
   endgenerate
   // Transmit bytes queue here, tagged with their channel
   tsis_fifo #(
      .W(10),
      .AW(FIFO_AW)
   ) u_fifo (
      .pclk(pclk),
      .presetn(presetn),
      .in_valid(push),
      .in_ready(f_in_ready),
      .in_data(pwdata[9:0]),
      .out_valid(f_valid),
      .out_ready(|take),
      .out_data(f_data),
      .level(f_level)
   );
   // One wait state so read data and errors come from flops
   assign done = psel & penable & pready_q;
   assign push = done & pwrite & (paddr == `TSIS_TXD_OFF) & ~pslverr_q;
   assign rd_clr[0] = done & ~pwrite & (paddr == `TSIS_RX1_OFF);
   assign rd_clr[1] = done & ~pwrite & (paddr == `TSIS_RX2_OFF);
   assign rd_clr[2] = done & ~pwrite & (paddr == `TSIS_RX3_OFF);
   // Read mux and error decode; full FIFO refuses the write
   always @* begin
      rd_d = 32'h00000000;
      err_d = 1'b0;
      case (paddr)
         `TSIS_ROUTE_OFF: rd_d = {16'h0000, route_q};
         `TSIS_MODE_OFF: rd_d = {8'h00, mode_q};
         `TSIS_DIV_OFF: rd_d = {16'h0000, div_q};
         `TSIS_GRP_OFF: rd_d = {30'h00000000, grp_q};
         `TSIS_TXD_OFF: err_d = pwrite & ~f_in_ready;
         `TSIS_STAT_OFF: rd_d = {9'h000, on_mux, 1'b0, busy_w, 1'b0, run, 1'b0, rxf_w,
                                 2'h0, ~f_in_ready, f_level};
         `TSIS_RX1_OFF: rd_d = {24'h000000, rxb_w[7:0]};
         `TSIS_RX2_OFF: rd_d = {24'h000000, rxb_w[15:8]};
         `TSIS_RX3_OFF: rd_d = {24'h000000, rxb_w[23:16]};
         default: err_d = 1'b1;
      endcase
   end
   // Register writes land at the completing edge only
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         route_q <= `TSIS_ROUTE_RST;
         mode_q <= `TSIS_MODE_RST;
         div_q <= `TSIS_DIV_RST;
         grp_q <= `TSIS_GRP_RST;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h00000000;
      end else begin
         pready_q <= psel & penable & ~pready_q;
         if (psel && penable && !pready_q) begin
            prdata_q <= pwrite ? 32'h00000000 : rd_d;
            pslverr_q <= err_d;
         end else if (!psel) begin
            pslverr_q <= 1'b0;
         end
         if (done && pwrite && !pslverr_q) begin
            case (paddr)
               `TSIS_ROUTE_OFF: route_q <= pwdata[15:0];
               `TSIS_MODE_OFF: mode_q <= pwdata[23:0];
               `TSIS_DIV_OFF: div_q <= pwdata[15:0];
               `TSIS_GRP_OFF: grp_q <= pwdata[1:0];
               default: route_q <= route_q;
            endcase
         end
      end
   end
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign tclk_o = tclk_o_q;
   assign tclk_oe_n = tclk_oe_n_q;
endmodule

// *** test/tsis_top_chk.sv ***
`timescale 1ns/1ps
// ****
// Router port checks
// ****
module tsis_chk (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire [2:0] txd,
   input wire [2:0] tclk_i,
   input wire [2:0] rts_n,
   input wire [2:0] cts_n
);
   reg [4:0] route_q;
   reg seen_q;
   wire rt_hit = psel && penable && pready && paddr == 8'h00;
   // Routing shadow, coded bits only
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         route_q <= 5'h00;
         seen_q <= 1'b0;
      end else if (rt_hit && pwrite) begin
         route_q <= pwdata[4:0] & 5'h1b;
         seen_q <= 1'b1;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_one_wait: assert property (psel && penable && !pready |=> pready)
      else $error("no answer after one wait");
   a_route_reset: assert property (rt_hit && !pwrite && !seen_q |-> prdata[15:0] == 16'h0)
      else $error("routing not zero");
   a_route_back: assert property (rt_hit && !pwrite && seen_q |-> prdata[4:0] == route_q)
      else $error("routing readback wrong");
   a_mux_quiet: assert property ((route_q[1:0] != 2'h0 && route_q[3])[*3] |-> txd[1])
      else $error("muxed channel two pin active");
   a_idle_two: assert property (!txd[1] |-> ##[0:3] !rts_n[1])
      else $error("channel two zero while idle");
   a_idle_three: assert property (!txd[2] |-> ##[0:3] !rts_n[2])
      else $error("channel three zero while idle");
   a_ext_edge: assert property ($changed(txd[2]) |-> !tclk_i[2] &&
      ($past(tclk_i[2], 2) || $past(tclk_i[2], 3) || $past(tclk_i[2], 4)))
      else $error("channel three bit off clock");
   a_cts_gate: assert property ($fell(rts_n[1]) |-> !$past(cts_n[1], 2))
      else $error("send without clear");
   cover property (rt_hit && pwrite && pwdata[15:0] == 16'h0009);
   cover property ($fell(rts_n[1]));
   cover property ($fell(rts_n[2]));
endmodule
bind tsis_top tsis_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .txd(txd), .tclk_i(tclk_i), .rts_n(rts_n), .cts_n(cts_n));

// *** test/tsis_far_end.sv ***
`timescale 1ns/1ps
// ****
// Far-end loopback transceiver
// ****
module tsis_far_end (
   input wire pclk,
   input wire presetn,
   input wire [2:0] txd,
   input wire [2:0] tclk_o,
   input wire [2:0] tclk_oe_n,
   input wire [2:0] rts_n,
   input wire [2:0] cts_stall,
   input wire run_ext,
   input wire l1_run,
   input wire sync_on,
   input wire mux_on,
   output wire [2:0] tclk_i,
   output wire [2:0] rxd,
   output wire [2:0] rclk,
   output wire [2:0] cts_n,
   output wire [2:0] cd_n
);
   reg [2:0] div_q;
   reg ext_q;
   reg l1_q;
   reg [2:0] cd_q;
   // Slow clocks, eight cycles a half; still unless asked
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= 3'h0;
         ext_q <= 1'b0;
         l1_q <= 1'b0;
         cd_q <= 3'h7;
      end else begin
         div_q <= div_q + 3'h1;
         if (div_q == 3'h7) begin
            ext_q <= run_ext & ~ext_q;
            l1_q <= l1_run & ~l1_q;
         end
         cd_q <= {rts_n[2:1], mux_on ? ~sync_on : rts_n[0]};
      end
   end
   // Pin level from both drivers; we clock only where the device floats
   assign tclk_i = (tclk_oe_n & {ext_q, 2'h0}) | (~tclk_oe_n & tclk_o);
   assign rclk = {tclk_i[2:1], mux_on ? l1_q : tclk_i[0]};
   // Idle line shows the inverse, never a stale copy
   assign rxd = txd ^ cd_q;
   assign cts_n = cts_stall;
   assign cd_n = cd_q;
endmodule

// *** test/transparent_serial_interface_select_bench.sv ***
`timescale 1ns/1ps
// ****
// Router bench
// ****
module transparent_serial_interface_select_bench;
   reg pclk = 1'b0;
   reg presetn = 1'b0;
   reg psel = 1'b0;
   reg penable = 1'b0;
   reg pwrite = 1'b0;
   reg [7:0] paddr = 8'h00;
   reg [31:0] pwdata = 32'h0;
   reg [2:0] cts_stall = 3'h0;
   reg run_ext = 1'b0;
   reg l1_run = 1'b0;
   reg sync_on = 1'b0;
   reg mux_on = 1'b0;
   wire [31:0] prdata;
   wire pready;
   wire pslverr;
   wire [2:0] txd, tclk_i, tclk_o, tclk_oe_n, rxd, rclk, rts_n, cts_n, cd_n;
   integer n_errors = 0;
   integer samples_checked = 0;
   integer i;
   integer m;
   integer z;
   reg [31:0] q;
   reg e;
   // 40 MHz clock
   always #12.5 pclk = ~pclk;
   tsis_top #(.FIFO_AW(4)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .txd(txd), .tclk_i(tclk_i), .tclk_o(tclk_o),
      .tclk_oe_n(tclk_oe_n), .rxd(rxd), .rclk(rclk), .rts_n(rts_n), .cts_n(cts_n),
      .cd_n(cd_n));
   tsis_far_end u_far (.pclk(pclk), .presetn(presetn), .txd(txd), .tclk_o(tclk_o),
      .tclk_oe_n(tclk_oe_n), .rts_n(rts_n), .cts_stall(cts_stall), .run_ext(run_ext),
      .l1_run(l1_run), .sync_on(sync_on), .mux_on(mux_on), .tclk_i(tclk_i), .rxd(rxd),
      .rclk(rclk), .cts_n(cts_n), .cd_n(cd_n));
   // Verdict and end of run
   task end_sim;
      begin
         $display("checked %0d errors %0d", samples_checked, n_errors);
         if (n_errors == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   task chk(input string nm, input [31:0] x, input [31:0] g);
      begin
         samples_checked = samples_checked + 1;
         if (g !== x) begin
            n_errors = n_errors + 1;
            $display("unexpected %0s: expected %h seen %h", nm, x, g);
         end
      end
   endtask
   // One APB transfer, held until pready is seen
   task apb(input w, input [7:0] a, input [31:0] d);
      integer n;
      begin
         @(posedge pclk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         n = 0;
         do begin
            @(posedge pclk);
            n = n + 1;
         end while (pready !== 1'b1 && n < 50);
         if (n >= 50) begin
            n_errors = n_errors + 1;
            end_sim;
         end
         q = prdata;
         e = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   // Bounded status poll
   task poll(input [31:0] msk, input [31:0] val);
      integer n;
      begin
         n = 0;
         q = ~val;
         while ((q & msk) !== val && n < 600) begin
            apb(1'b0, 8'h14, 32'h0);
            n = n + 1;
         end
         chk("status", val, q & msk);
      end
   endtask
   task t_regs;
      begin
         chk("idle txd", 32'h7, {29'h0, txd});
         apb(1'b0, 8'h00, 32'h0);
         chk("route rst", 32'h0, q);
         apb(1'b1, 8'h00, 32'h9);
         apb(1'b0, 8'h00, 32'h0);
         chk("route 9", 32'h9, q & 32'h1b);
         apb(1'b0, 8'hfc, 32'h0);
         chk("unmapped", 32'h1, {31'h0, e});
         apb(1'b1, 8'h00, 32'h0);
      end
   endtask
   // Channel three clocked by the far end
   task t_own;
      begin
         apb(1'b1, 8'h08, 32'h4);
         apb(1'b1, 8'h04, 32'h0f0707);
         run_ext <= 1'b1;
         apb(1'b1, 8'h10, 32'h23c);
         poll(32'h400, 32'h400);
         apb(1'b0, 8'h20, 32'h0);
         chk("rx3", 32'h3c, q & 32'hff);
         run_ext <= 1'b0;
      end
   endtask
   // Fill while clear-to-send is withheld, then drain
   task t_fill;
      begin
         cts_stall <= 3'h2;
         for (i = 0; i < 17; i = i + 1) begin
            apb(1'b1, 8'h10, {22'h0, 2'h1, i[3:0], ~i[3:0]});
            chk("refused", {31'h0, i == 16}, {31'h0, e});
         end
         apb(1'b0, 8'h14, 32'h0);
         chk("full", 32'h30, q & 32'h3f);
         chk("rts held", 32'h1, {31'h0, rts_n[1]});
         cts_stall <= 3'h0;
         poll(32'h1f, 32'h0);
         for (i = 0; i < 400 && rts_n[1] !== 1'b1; i = i + 1) @(posedge pclk);
         apb(1'b0, 8'h1c, 32'h0);
         chk("rx2 last", 32'hf0, q & 32'hff);
         chk("idle ones", 32'h7, {29'h0, txd});
      end
   endtask
   // Channel one on each muxed route; last pass is grouped PCM via 0009
   task t_mux;
      begin
         mux_on <= 1'b1;
         l1_run <= 1'b1;
         for (m = 1; m < 5; m = m + 1) begin
            apb(1'b1, 8'h04, 32'h0);
            apb(1'b1, 8'h0c, m / 4);
            apb(1'b1, 8'h00, (m > 3 ? 1 : m) | 32'h8);
            apb(1'b1, 8'h04, 32'h0f0707);
            apb(1'b1, 8'h10, 32'h0);
            if (m > 3) apb(1'b1, 8'h10, 32'h0);
            z = 0;
            for (i = 0; i < 130; i = i + 1) begin
               sync_on <= (i >= 26) && (i % 26 < 24);
               @(posedge rclk[0]);
               repeat (5) @(posedge pclk);
               z = z + (txd[0] === 1'b0);
               if (i == 25) chk("no sync", 32'h0, z);
               if (i == 49) chk("frame one zeros", (m > 3) ? 16 : 8, z);
            end
            chk("slot zeros", (m > 3) ? 16 : 8, z);
         end
      end
   endtask
   // Ten reset cycles, then the scenarios
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_own;
      t_fill;
      t_mux;
      end_sim;
   end
   // Watchdog, well above the longest run
   initial begin
      #(25 * 20000);
      n_errors = n_errors + 1;
      end_sim;
   end
endmodule
